// file: logic/srm_resp_mode.sv
/*
 Initial-setting register window, apply-setup handling and response-mode decisions.
 Assumes host window accesses and sequencer events on mclk_in; bus pins arrive asynchronously.
*/
// Function
// - Window writes only take effect when the apply-setup command runs.
// - Successful apply-setup pulses the command-done output.
// - Apply-setup while not ready or auto-responding is refused and changes nothing.
// - Clock conversion codes select input and internal frequencies.
// - Own identity register holds the bus ID as plain binary.
// - Bit 7 enables answering reselection as initiator; otherwise BSY stays off.
// - Bit 6 enables answering selection as target; otherwise BSY stays off.
// - Initiator message-in phase error: receive one message or report initial phase error.
// - Initiator status phase error with auto receive: take one status, then interrupt.
// - Status reception errors reuse the phase-error step number.
// - Phase error during a transfer reports in-transfer phase error, no auto receive.
// - Target final-ACK attention: take one message or report complete with attention.
// - Commands ending in message-out report complete with attention unless the attention repeats.
// - Target boundary attention stops at block; message or command-stop with attention.
// - Local parity block stop with attention reports the parity error only.
// - Repeated attention after auto message-out reports 61H with step plus one.
// - Received bytes start at buffer 0, or after the CDB for command phase.
// - Bit 4 stops data parity errors at the byte; otherwise at block end.
// - Odd data byte count makes block-unit parity stops two blocks.
// - Bit 1 accepts single-ID selection with nexus status 000; else two IDs.
// - As initiator, selection always drives both own and target ID bits.
// - Bit 0 skips arbitration; cleared performs arbitration.
`timescale 1ns/100ps
module srm_resp_mode
	import srm_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	// Host window port
	input  wire logic [4:0]  win_addr_in,
	input  wire logic        win_wr_in,
	input  wire logic [7:0]  win_wdata_in,
	output logic      [7:0]  win_rdata_out,
	// Commands
	input  wire logic        setup_cmd_in,
	input  wire logic        cmd_ready_in,
	input  wire logic        auto_busy_in,
	output logic             cmd_done_out,
	output logic             cmd_reject_out,
	// Active configuration
	output srm_cfg_t         cfg_out,
	output logic             clk_code_valid_out,
	output logic             arb_skip_out,
	// SCSI bus pins
	input  wire logic        scsi_sel_in,
	input  wire logic        scsi_io_in,
	input  wire logic        scsi_atn_in,
	input  wire logic [7:0]  scsi_db_in,
	output logic             bsy_oe_n_out,
	output logic             nexus_single_out,
	output logic [7:0]       sel_ids_out,
	// Sequencer events
	input  wire logic        role_target_in,
	input  wire logic [2:0]  target_id_in,
	input  srm_evt_t         evt_in,
	input  wire logic [7:0]  step_in,
	input  wire logic        recv_done_in,
	input  wire logic        recv_err_in,
	input  wire logic [4:0]  cdb_len_in,
	input  wire logic        data_byte_odd_in,
	// Automatic receive and reporting
	output logic             msgout_enter_out,
	output logic             recv_req_out,
	output logic [4:0]       recv_addr_out,
	output logic             intr_valid_out,
	output logic [7:0]       intr_code_out,
	output logic [7:0]       intr_step_out,
	output logic             stop_now_out,
	output logic             stop_at_block_out,
	output logic [1:0]       block_unit_out
);

////////////////////////////////////////////////////////////////////////////////

typedef struct packed {
	logic [15:0][7:0] win;
	srm_cfg_t         cfg;
	logic [7:0]       rdata;
	logic             done;
	logic             rej;
	logic [1:0]       sel_s;
	logic [1:0]       io_s;
	logic [1:0]       atn_s;
	logic [1:0][7:0]  db_s;
	logic             sel_prev;
	logic             bsy_drv;
	logic             single;
	srm_ar_state_t    ar;
	logic [7:0]       code;
	logic [7:0]       step;
	logic             auto_done;
	logic [4:0]       raddr;
	logic             msgout;
	logic             rreq;
	logic             ivalid;
	logic [7:0]       icode;
	logic [7:0]       istep;
	logic             stop_now;
	logic             stop_blk;
	logic [1:0]       blk;
} srm_state_t;

srm_state_t st_reg;
srm_state_t st_next;

logic       auto_rx;
logic       sel_rise;
logic [3:0] id_count;
logic       own_seen;
logic       apply_ok;

assign auto_rx  = st_reg.cfg.resp[SRM_RB_AUTO];
assign sel_rise = st_reg.sel_s[1] & ~st_reg.sel_prev;
assign id_count = 4'($countones(st_reg.db_s[1]));
assign own_seen = st_reg.db_s[1][st_reg.cfg.own_id[2:0]];
assign apply_ok = cmd_ready_in & ~auto_busy_in;

////////////////////////////////////////////////////////////////////////////////

always_comb begin
	st_next          = st_reg;
	st_next.done     = 1'b0;
	st_next.rej      = 1'b0;
	st_next.msgout   = 1'b0;
	st_next.rreq     = 1'b0;
	st_next.ivalid   = 1'b0;
	st_next.stop_now = 1'b0;
	st_next.stop_blk = 1'b0;

	// Pins: two flops before use
	st_next.sel_s    = {st_reg.sel_s[0], scsi_sel_in};
	st_next.io_s     = {st_reg.io_s[0], scsi_io_in};
	st_next.atn_s    = {st_reg.atn_s[0], scsi_atn_in};
	st_next.db_s     = {st_reg.db_s[0], scsi_db_in};
	st_next.sel_prev = st_reg.sel_s[1];

	// Host writes land only in the window copy
	if (win_wr_in && win_addr_in[4] == SRM_WIN_SEL && win_addr_in != SRM_ADDR_HOLE) begin
		st_next.win[win_addr_in[3:0]] = win_wdata_in;
	end
	st_next.rdata = (win_addr_in[4] == SRM_WIN_SEL && win_addr_in != SRM_ADDR_HOLE) ?
		st_reg.win[win_addr_in[3:0]] : 8'h00;

	// Apply-setup copies the clock conversion, own ID and response-mode window registers into the live configuration
	if (setup_cmd_in) begin
		if (apply_ok) begin
			st_next.cfg.clk_conv = st_reg.win[SRM_ADDR_CLK_CONV[3:0]];
			st_next.cfg.own_id   = st_reg.win[SRM_ADDR_OWN_ID[3:0]];
			st_next.cfg.resp     = st_reg.win[SRM_ADDR_RESP[3:0]];
			st_next.done         = 1'b1;
		end else begin
			st_next.rej = 1'b1;
		end
	end

	// Selection and reselection answer; BSY held until SEL drops
	if (!st_reg.sel_s[1]) begin
		st_next.bsy_drv = 1'b0;
	end else if (sel_rise && own_seen) begin
		if (!st_reg.io_s[1] && role_target_in && st_reg.cfg.resp[SRM_RB_SEL]) begin
			if (id_count == 4'h2) begin
				st_next.bsy_drv = 1'b1;
				st_next.single  = 1'b0;
			end else if (id_count == 4'h1 && st_reg.cfg.resp[SRM_RB_SINGLE]) begin
				st_next.bsy_drv = 1'b1;
				st_next.single  = 1'b1;
			end
		end else if (st_reg.io_s[1] && !role_target_in && st_reg.cfg.resp[SRM_RB_RESEL]
			&& id_count == 4'h2) begin
			st_next.bsy_drv = 1'b1;
			st_next.single  = 1'b0;
		end
	end

	// Data-phase parity stop mode
	if (evt_in.dp_par) begin
		st_next.stop_now = st_reg.cfg.resp[SRM_RB_PARBYT];
		st_next.stop_blk = ~st_reg.cfg.resp[SRM_RB_PARBYT];
	end
	st_next.blk = data_byte_odd_in ? SRM_BLK_TWO : SRM_BLK_ONE;

	// New connection closes the repeated-attention window; a receive ending now still arms it
	if (sel_rise) begin
		st_next.auto_done = 1'b0;
	end

	// Automatic receive sequencer
	case (st_reg.ar)
	SRM_AR_IDLE: begin
		// Step only captured on events, so a later repeated attention sees the old one
		if (evt_in.ph_err || evt_in.atn_bound || evt_in.atn_final) begin
			st_next.step = step_in;
		end
		st_next.raddr = (role_target_in && evt_in.after_cmd) ? cdb_len_in : SRM_RBUF_START;
		if (evt_in.ph_err && !role_target_in) begin
			st_next.auto_done = 1'b0;
			if (evt_in.in_xfer) begin
				st_next.code = SRM_INT_PE_XFER;
				st_next.ar   = SRM_AR_REPORT;
			end else if (evt_in.req_sts && auto_rx) begin
				st_next.code = SRM_INT_IPE_STS;
				st_next.ar   = SRM_AR_WAIT_ATN;
			end else if (evt_in.req_msg) begin
				st_next.code = auto_rx ? SRM_INT_IPE_MSG : SRM_INT_IPE;
				st_next.ar   = SRM_AR_WAIT_ATN;
			end else begin
				st_next.code = SRM_INT_IPE;
				st_next.ar   = SRM_AR_REPORT;
			end
		end else if (evt_in.atn_bound && role_target_in) begin
			st_next.stop_blk = 1'b1;
			if (evt_in.dma_par || evt_in.mpu_par) begin
				st_next.code = evt_in.dma_par ? SRM_INT_DMA_PAR : SRM_INT_MPU_PAR;
				st_next.ar   = SRM_AR_REPORT;
			end else if (st_reg.auto_done) begin
				st_next.code = SRM_INT_REPEAT_ATN;
				st_next.step = st_reg.step + 8'h01;
				st_next.ar   = SRM_AR_REPORT;
			end else begin
				st_next.code = auto_rx ? SRM_INT_STOP_ATNMSG : SRM_INT_STOP_ATN;
				st_next.ar   = auto_rx ? SRM_AR_MSGOUT : SRM_AR_REPORT;
			end
		end else if (evt_in.atn_final && role_target_in) begin
			if (st_reg.auto_done) begin
				st_next.code = SRM_INT_REPEAT_ATN;
				st_next.step = st_reg.step + 8'h01;
				st_next.ar   = SRM_AR_REPORT;
			end else if (evt_in.ends_msgout || !auto_rx) begin
				st_next.code = SRM_INT_CC_ATN;
				st_next.ar   = SRM_AR_REPORT;
			end else begin
				st_next.code = SRM_INT_CC_ATN_MSG;
				st_next.ar   = SRM_AR_MSGOUT;
			end
		end
	end
	SRM_AR_WAIT_ATN: begin
		// Initiator holds off until the target sees ATN negated
		if (!st_reg.atn_s[1]) begin
			st_next.rreq = (st_reg.code != SRM_INT_IPE);
			st_next.ar   = (st_reg.code == SRM_INT_IPE) ? SRM_AR_REPORT : SRM_AR_RECV;
		end
	end
	SRM_AR_MSGOUT: begin
		st_next.msgout = 1'b1;
		st_next.rreq   = 1'b1;
		st_next.ar     = SRM_AR_RECV;
	end
	SRM_AR_RECV: begin
		if (recv_err_in) begin
			st_next.code = SRM_INT_RECV_ERR;
			st_next.ar   = SRM_AR_REPORT;
		end else if (recv_done_in) begin
			st_next.auto_done = role_target_in;
			st_next.ar        = SRM_AR_REPORT;
		end
	end
	SRM_AR_REPORT: begin
		st_next.ivalid = 1'b1;
		st_next.icode  = st_reg.code;
		st_next.istep  = st_reg.step;
		st_next.ar     = SRM_AR_IDLE;
	end
	default: begin
		st_next.ar = SRM_AR_IDLE;
	end
	endcase
end

always_ff @(posedge mclk_in) begin
	if (sys_rst_in) begin
		st_reg <= '0;
	end else begin
		st_reg <= st_next;
	end
end

////////////////////////////////////////////////////////////////////////////////

assign win_rdata_out      = st_reg.rdata;
assign cmd_done_out       = st_reg.done;
assign cmd_reject_out     = st_reg.rej;
assign cfg_out            = st_reg.cfg;
assign arb_skip_out       = st_reg.cfg.resp[SRM_RB_NOARB];
assign clk_code_valid_out = st_reg.cfg.clk_conv inside {SRM_CC_20_20, SRM_CC_20_10, SRM_CC_30_15,
	SRM_CC_30_10, SRM_CC_40_20, SRM_CC_40_13};
assign bsy_oe_n_out       = ~st_reg.bsy_drv;
assign nexus_single_out   = st_reg.single;
// Initiator selection always puts both IDs on the bus; bit 1 is ignored here
assign sel_ids_out        = (8'h01 << st_reg.cfg.own_id[2:0]) | (8'h01 << target_id_in);
assign msgout_enter_out   = st_reg.msgout;
assign recv_req_out       = st_reg.rreq;
assign recv_addr_out      = st_reg.raddr;
assign intr_valid_out     = st_reg.ivalid;
assign intr_code_out      = st_reg.icode;
assign intr_step_out      = st_reg.istep;
assign stop_now_out       = st_reg.stop_now;
assign stop_at_block_out  = st_reg.stop_blk;
assign block_unit_out     = st_reg.blk;

////////////////////////////////////////////////////////////////////////////////

sequence apply_accepted;
	setup_cmd_in && apply_ok;
endsequence

sequence apply_refused;
	setup_cmd_in && !apply_ok;
endsequence

cfg_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	!setup_cmd_in |=> $stable(cfg_out)) else $error("config changed without apply");
apply_done_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	apply_accepted |=> cmd_done_out && !cmd_reject_out) else $error("apply not completed");
apply_rej_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	apply_refused |=> cmd_reject_out && !cmd_done_out && $stable(cfg_out)) else $error("refusal wrong");
no_resel_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	$rose(st_reg.bsy_drv) && st_reg.io_s[1] |-> $past(cfg_out.resp[SRM_RB_RESEL])) else $error("resel answered");
no_sel_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	$rose(st_reg.bsy_drv) && !st_reg.io_s[1] |-> $past(cfg_out.resp[SRM_RB_SEL])) else $error("sel answered");
xfer_pe_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	st_reg.ar == SRM_AR_IDLE && evt_in.ph_err && evt_in.in_xfer && !role_target_in
	|-> ##2 intr_valid_out && intr_code_out == SRM_INT_PE_XFER && !recv_req_out) else $error("xfer pe");
par_byte_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	evt_in.dp_par |=> stop_now_out == cfg_out.resp[SRM_RB_PARBYT]
	&& stop_at_block_out != stop_now_out) else $error("parity stop mode");
single_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	$rose(nexus_single_out) |-> !bsy_oe_n_out && cfg_out.resp[SRM_RB_SINGLE]) else $error("single id");
ids_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	sel_ids_out[target_id_in] && sel_ids_out[cfg_out.own_id[2:0]]) else $error("sel ids");
msg_rx_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	msgout_enter_out |-> recv_req_out ##1 st_reg.ar == SRM_AR_RECV) else $error("msgout sequence");
repeat_atn_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	st_reg.ar == SRM_AR_IDLE && role_target_in && evt_in.atn_final && st_reg.auto_done
	|=> st_reg.code == SRM_INT_REPEAT_ATN && st_reg.step == $past(st_reg.step) + 8'h01) else $error("repeat atn");
blk_unit_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
	data_byte_odd_in |=> block_unit_out == SRM_BLK_TWO) else $error("block unit");

endmodule

// file: logic/srm_pkg.sv
/*
 Shared constants and types for the initial-setting window and response-mode block.
 Assumes one 250 MHz clock and a synchronous active-high reset.
*/
package srm_pkg;
	// Window addresses (A4..A0)
	localparam logic [4:0] SRM_ADDR_CLK_CONV  = 5'h10;
	localparam logic [4:0] SRM_ADDR_OWN_ID    = 5'h11;
	localparam logic [4:0] SRM_ADDR_RESP      = 5'h12;
	localparam logic [4:0] SRM_ADDR_SEL_AUTO  = 5'h13;
	localparam logic [4:0] SRM_ADDR_SEL_RETRY = 5'h14;
	localparam logic [4:0] SRM_ADDR_SEL_TMO   = 5'h15;
	localparam logic [4:0] SRM_ADDR_HS_TMO    = 5'h16;
	localparam logic [4:0] SRM_ADDR_ASYNC_SU  = 5'h17;
	localparam logic [4:0] SRM_ADDR_PARITY    = 5'h18;
	localparam logic [4:0] SRM_ADDR_INT_EN    = 5'h19;
	localparam logic [4:0] SRM_ADDR_CMD_LEN   = 5'h1A;
	localparam logic [4:0] SRM_ADDR_DMA_CFG   = 5'h1B;
	localparam logic [4:0] SRM_ADDR_AUTO_OPT  = 5'h1C;
	localparam logic [4:0] SRM_ADDR_WDOG      = 5'h1D;
	localparam logic [4:0] SRM_ADDR_REV       = 5'h1F;
	localparam logic       SRM_WIN_SEL        = 1'h1;
	localparam logic [4:0] SRM_ADDR_HOLE      = 5'h1E;

	// Response-mode bit positions
	localparam int SRM_RB_RESEL  = 7;
	localparam int SRM_RB_SEL    = 6;
	localparam int SRM_RB_AUTO   = 5;
	localparam int SRM_RB_PARBYT = 4;
	localparam int SRM_RB_SINGLE = 1;
	localparam int SRM_RB_NOARB  = 0;

	// Clock conversion codes: input / internal MHz
	localparam logic [7:0] SRM_CC_20_20 = 8'h0B;
	localparam logic [7:0] SRM_CC_20_10 = 8'h10;
	localparam logic [7:0] SRM_CC_30_15 = 8'h32;
	localparam logic [7:0] SRM_CC_30_10 = 8'h38;
	localparam logic [7:0] SRM_CC_40_20 = 8'h53;
	localparam logic [7:0] SRM_CC_40_13 = 8'h59;

	// Interrupt codes; only the repeated-attention code is fixed, the rest are arbitrary
	localparam logic [7:0] SRM_INT_CMD_DONE    = 8'h01;
	localparam logic [7:0] SRM_INT_CMD_REJ     = 8'h02;
	localparam logic [7:0] SRM_INT_IPE         = 8'h10;
	localparam logic [7:0] SRM_INT_IPE_MSG     = 8'h11;
	localparam logic [7:0] SRM_INT_IPE_STS     = 8'h12;
	localparam logic [7:0] SRM_INT_PE_XFER     = 8'h13;
	localparam logic [7:0] SRM_INT_CC_ATN      = 8'h20;
	localparam logic [7:0] SRM_INT_CC_ATN_MSG  = 8'h21;
	localparam logic [7:0] SRM_INT_STOP_ATN    = 8'h30;
	localparam logic [7:0] SRM_INT_STOP_ATNMSG = 8'h31;
	localparam logic [7:0] SRM_INT_DMA_PAR     = 8'h40;
	localparam logic [7:0] SRM_INT_MPU_PAR     = 8'h41;
	localparam logic [7:0] SRM_INT_RECV_ERR    = 8'h50;
	localparam logic [7:0] SRM_INT_REPEAT_ATN  = 8'h61;
	localparam logic [4:0] SRM_RBUF_START      = 5'h00;
	localparam logic [1:0] SRM_BLK_ONE         = 2'h1;
	localparam logic [1:0] SRM_BLK_TWO         = 2'h2;

	typedef struct packed {
		logic [7:0] clk_conv;
		logic [7:0] own_id;
		logic [7:0] resp;
	} srm_cfg_t;

	// One-cycle event pulses with qualifiers from the sequencer
	typedef struct packed {
		logic ph_err;
		logic in_xfer;
		logic req_msg;
		logic req_sts;
		logic atn_final;
		logic ends_msgout;
		logic atn_bound;
		logic dma_par;
		logic mpu_par;
		logic after_cmd;
		logic dp_par;
	} srm_evt_t;

	typedef enum logic [2:0] {
		SRM_AR_IDLE,
		SRM_AR_WAIT_ATN,
		SRM_AR_MSGOUT,
		SRM_AR_RECV,
		SRM_AR_REPORT
	} srm_ar_state_t;
endpackage

// file: tb/srm_bus_peer.sv
/*
 Bus-side peer model: drives selection, attention and one-byte receive replies.
 Assumes bench requests change on mclk_in edges; terminated bus lines read 0 when released.
*/
`timescale 1ns/100ps
module srm_bus_peer
	import srm_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	// Bench requests
	input  wire logic       sel_req_in,
	input  wire logic       resel_in,
	input  wire logic [7:0] ids_in,
	input  wire logic       atn_req_in,
	input  wire logic       err_in,
	input  wire logic [3:0] lat_in,
	// Device side
	input  wire logic       recv_req_in,
	output logic            scsi_sel_out,
	output logic            scsi_io_out,
	output logic            scsi_atn_out,
	output logic [7:0]      scsi_db_out,
	output logic            recv_done_out,
	output logic            recv_err_out
);
	logic [3:0] wait_reg;
	// Released data lines fall to the terminated idle level
	assign scsi_sel_out = sel_req_in;
	assign scsi_io_out  = sel_req_in & resel_in;
	assign scsi_db_out  = sel_req_in ? ids_in : 8'h00;
	assign scsi_atn_out = atn_req_in;
	// Byte source of varying speed, so prompt and slow replies both occur
	always_ff @(posedge mclk_in) begin
		recv_done_out <= 1'b0;
		recv_err_out  <= 1'b0;
		if (sys_rst_in) begin
			wait_reg <= 4'h0;
		end else if (recv_req_in) begin
			wait_reg <= lat_in;
		end else if (wait_reg != 4'h0) begin
			wait_reg      <= wait_reg - 4'h1;
			recv_done_out <= (wait_reg == 4'h1) & ~err_in;
			recv_err_out  <= (wait_reg == 4'h1) & err_in;
		end
	end
endmodule

// file: tb/tb.sv
/*
 Self-checking bench for the setting window and response-mode block.
 Assumes srm_pkg and the bus peer model are compiled first.
*/
`timescale 1ns/100ps
module tb;
	import srm_pkg::*;
	logic       clk, rst, wr, setup, ready, busy, role, odd, sel_req, resel, atn, err;
	logic [4:0] addr, cdb, raddr;
	logic [7:0] wdata, step, ids, rdata, icode, istep, sids, r, s;
	logic [2:0] tid;
	logic [3:0] lat;
	logic [1:0] bunit;
	srm_evt_t   evt;
	srm_cfg_t   cfg;
	wire logic  sel, io, atnp, rdone, rerr;
	wire logic [7:0] db;
	logic       done, rej, ccv, askip, bsy_n, single, msgo, rreq, ivalid, snow, sblk;
	logic       s_done, s_rej, s_msg, s_rreq, s_int, s_now, s_blk;
	logic [7:0] g_code, g_step, shadow [32];
	logic [4:0] g_addr;
	logic [7:0] codes [6] = '{8'h0B, 8'h10, 8'h32, 8'h38, 8'h53, 8'h59};
	int         miscompares, n_compared, cycles;
	srm_resp_mode uut (.mclk_in(clk), .sys_rst_in(rst), .win_addr_in(addr), .win_wr_in(wr),
		.win_wdata_in(wdata), .win_rdata_out(rdata), .setup_cmd_in(setup), .cmd_ready_in(ready),
		.auto_busy_in(busy), .cmd_done_out(done), .cmd_reject_out(rej), .cfg_out(cfg),
		.clk_code_valid_out(ccv), .arb_skip_out(askip), .scsi_sel_in(sel), .scsi_io_in(io),
		.scsi_atn_in(atnp), .scsi_db_in(db), .bsy_oe_n_out(bsy_n), .nexus_single_out(single),
		.sel_ids_out(sids), .role_target_in(role), .target_id_in(tid), .evt_in(evt), .step_in(step),
		.recv_done_in(rdone), .recv_err_in(rerr), .cdb_len_in(cdb), .data_byte_odd_in(odd),
		.msgout_enter_out(msgo), .recv_req_out(rreq), .recv_addr_out(raddr), .intr_valid_out(ivalid),
		.intr_code_out(icode), .intr_step_out(istep), .stop_now_out(snow),
		.stop_at_block_out(sblk), .block_unit_out(bunit));
	srm_bus_peer peer (.mclk_in(clk), .sys_rst_in(rst), .sel_req_in(sel_req), .resel_in(resel),
		.ids_in(ids), .atn_req_in(atn), .err_in(err), .lat_in(lat), .recv_req_in(rreq),
		.scsi_sel_out(sel), .scsi_io_out(io), .scsi_atn_out(atnp), .scsi_db_out(db),
		.recv_done_out(rdone), .recv_err_out(rerr));
	////////////////////////////////////////
	task automatic close_out;
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		chk8(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		{addr, wr, wdata} <= {a, 1'b1, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic apply(input logic rdy, input logic bz);
		@(posedge clk);
		{s_done, s_rej, setup, ready, busy} <= {3'b001, rdy, bz};
		@(posedge clk);
		setup <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic setcfg(input logic [7:0] cc, input logic [7:0] id, input logic [7:0] rs);
		wr_reg(SRM_ADDR_CLK_CONV, cc);
		wr_reg(SRM_ADDR_OWN_ID, id);
		wr_reg(SRM_ADDR_RESP, rs);
		apply(1'b1, 1'b0);
		chk1("setup done", 1'b1, s_done);
	endtask
	task automatic sel_try(input logic rs, input logic [7:0] id, input logic bz, input logic sg);
		@(posedge clk);
		{sel_req, resel, ids} <= {1'b1, rs, id};
		repeat (6) @(posedge clk);
		chk1("bsy drive", bz, ~bsy_n);
		if (bz)
			chk1("nexus single", sg, single);
		sel_req <= 1'b0;
		repeat (6) @(posedge clk);
		chk1("bsy release", 1'b1, bsy_n);
	endtask
	task automatic fire(input srm_evt_t e, input logic [7:0] st);
		@(posedge clk);
		{s_msg, s_rreq, s_int, s_now, s_blk} <= 5'h00;
		{evt, step, lat} <= {e, st, 4'(2 + $urandom % 8)};
		@(posedge clk);
		evt <= '0;
	endtask
	task automatic expect_int(input logic [7:0] c, input logic [7:0] st);
		int n;
		n = 0;
		while (s_int !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk1("intr seen", 1'b1, s_int);
		chk8("intr code", c, g_code);
		chk8("intr step", st, g_step);
	endtask
	task automatic dp(input logic od, input logic nw, input logic [1:0] u);
		@(posedge clk);
		odd <= od;
		fire('{dp_par: 1'b1, default: 1'b0}, 8'h00);
		repeat (4) @(posedge clk);
		chk1("stop at byte", nw, s_now);
		chk1("stop at block", ~nw, s_blk);
		if (!nw)
			chk8("block unit", {6'h00, u}, {6'h00, bunit});
	endtask
	////////////////////////////////////////
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (done) s_done <= 1'b1;
		if (rej) s_rej <= 1'b1;
		if (msgo) s_msg <= 1'b1;
		if (rreq) {s_rreq, g_addr} <= {1'b1, raddr};
		if (ivalid) {s_int, g_code, g_step} <= {1'b1, icode, istep};
		if (snow) s_now <= 1'b1;
		if (sblk) s_blk <= 1'b1;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{rst, wr, setup, ready, busy, role, odd, sel_req, resel, atn, err} = 11'h400;
		{addr, wdata, step, tid, evt, ids, lat} = '0;
		{s_done, s_rej, s_msg, s_rreq, s_int, s_now, s_blk} = 7'h00;
		{miscompares, n_compared, cycles} = '0;
		r = 8'($urandom(32'h1fad));
		cdb = 5'(1 + $urandom % 12);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// Window writes and reads back; 0x1E is a hole
		for (int a = 16; a < 32; a++) begin
			r = 8'($urandom);
			shadow[a] = (a == 30) ? 8'h00 : r;
			wr_reg(5'(a), r);
		end
		for (int a = 16; a < 32; a++) begin
			@(posedge clk);
			addr <= 5'(a);
			repeat (2) @(posedge clk);
			chk8("window read", shadow[a], rdata);
		end
		chk8("resp before apply", 8'h00, cfg.resp);
		apply(1'b0, 1'b0);
		chk1("reject not ready", 1'b1, s_rej);
		apply(1'b1, 1'b1);
		chk1("reject busy", 1'b1, s_rej);
		chk8("own id after reject", 8'h00, cfg.own_id);
		apply(1'b1, 1'b0);
		chk1("setup done", 1'b1, s_done);
		chk8("resp applied", shadow[18], cfg.resp);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			tid <= 3'(i + 2);
			setcfg(codes[i], 8'(i), 8'(i % 2));
			chk1("clock code", 1'b1, ccv);
			chk1("skip arbitration", 1'(i % 2), askip);
			chk8("selection ids", (8'h01 << i) | (8'h04 << i), sids);
		end
		// Selection and reselection answers, own ID 3
		role <= 1'b1;
		setcfg(8'h0C, 8'h03, 8'h40);
		chk1("clock code", 1'b0, ccv);
		sel_try(1'b0, 8'h09, 1'b1, 1'b0);
		sel_try(1'b0, 8'h08, 1'b0, 1'b0);
		setcfg(8'h0B, 8'h03, 8'h42);
		sel_try(1'b0, 8'h08, 1'b1, 1'b1);
		setcfg(8'h0B, 8'h03, 8'h00);
		sel_try(1'b0, 8'h09, 1'b0, 1'b0);
		role <= 1'b0;
		setcfg(8'h0B, 8'h03, 8'h80);
		sel_try(1'b1, 8'h09, 1'b1, 1'b0);
		setcfg(8'h0B, 8'h03, 8'h00);
		sel_try(1'b1, 8'h09, 1'b0, 1'b0);
		// Target attention, with and without automatic receive
		role <= 1'b1;
		setcfg(8'h0B, 8'h03, 8'h60);
		s = 8'($urandom);
		fire('{atn_final: 1'b1, default: 1'b0}, s);
		expect_int(8'h21, s);
		chk1("msgout entered", 1'b1, s_msg);
		chk8("recv start", 8'h00, 8'(g_addr));
		fire('{atn_bound: 1'b1, default: 1'b0}, 8'h77);
		expect_int(8'h61, s + 8'h01);
		sel_try(1'b0, 8'h09, 1'b1, 1'b0);
		fire('{atn_final: 1'b1, after_cmd: 1'b1, default: 1'b0}, s);
		expect_int(8'h21, s);
		chk8("recv start", 8'(cdb), 8'(g_addr));
		sel_try(1'b0, 8'h09, 1'b1, 1'b0);
		fire('{atn_final: 1'b1, ends_msgout: 1'b1, default: 1'b0}, s);
		expect_int(8'h20, s);
		setcfg(8'h0B, 8'h03, 8'h40);
		fire('{atn_final: 1'b1, default: 1'b0}, s);
		expect_int(8'h20, s);
		fire('{atn_bound: 1'b1, default: 1'b0}, s);
		expect_int(8'h30, s);
		chk1("boundary stop", 1'b1, s_blk);
		atn <= 1'b1;
		fire('{atn_bound: 1'b1, dma_par: 1'b1, default: 1'b0}, s);
		expect_int(8'h40, s);
		fire('{atn_bound: 1'b1, mpu_par: 1'b1, default: 1'b0}, s);
		expect_int(8'h41, s);
		atn <= 1'b0;
		// Initiator phase errors
		role <= 1'b0;
		setcfg(8'h0B, 8'h03, 8'h20);
		fire('{ph_err: 1'b1, in_xfer: 1'b1, default: 1'b0}, s);
		expect_int(8'h13, s);
		chk1("no auto receive", 1'b0, s_rreq);
		atn <= 1'b1;
		fire('{ph_err: 1'b1, req_msg: 1'b1, default: 1'b0}, s);
		repeat (20) @(posedge clk);
		chk1("receive waits atn", 1'b0, s_rreq);
		atn <= 1'b0;
		expect_int(8'h11, s);
		fire('{ph_err: 1'b1, req_sts: 1'b1, default: 1'b0}, s);
		expect_int(8'h12, s);
		err <= 1'b1;
		fire('{ph_err: 1'b1, req_sts: 1'b1, default: 1'b0}, s);
		expect_int(8'h50, s);
		err <= 1'b0;
		setcfg(8'h0B, 8'h03, 8'h00);
		fire('{ph_err: 1'b1, req_msg: 1'b1, default: 1'b0}, s);
		expect_int(8'h10, s);
		// Data parity stops
		role <= 1'b1;
		setcfg(8'h0B, 8'h03, 8'h10);
		dp(1'b0, 1'b1, 2'h1);
		setcfg(8'h0B, 8'h03, 8'h00);
		dp(1'b0, 1'b0, 2'h1);
		dp(1'b1, 1'b0, 2'h2);
		close_out();
	end
endmodule
